// [logic/drcl_run_ctrl.sv]
// Run-command decoding, stop handling and auto-start of a motor drive
`include "drcl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Mode codes zero to five select behaviour
// - Nonzero mode overrides other run sources
// - Mode 1: forward/reverse levels, both stops
// - Mode 2: forward enables, reverse picks direction
// - Mode 3: enable level, direction pulses start
// - Mode 4: enable level, pulse starts, level direction
// - Mode 5: terminal pulses toggle run and stop
// - Terminal roles map onto any input
// - Stop mode 0 ramps down to zero
// - Stop mode 1 cuts output at once
// - Running up/down changes by configured step
// - Standby up/down changes by 0.01 Hz
// - Held up/down changes at configured rate
// - Mode 3 direction memory survives stops
// - Power-up auto-start after delay, prior direction
// - Without auto-start, stay stopped until commanded
// - Auto-start delay 0.1 to 3000.0 seconds
module drcl_run_ctrl
    import drcl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Digital input pins and up/down keys
    input wire logic [4:0] digital_input_i,
    input wire logic up_key_i,
    input wire logic down_key_i,
    // Terminal role assignment, index 0..4
    input wire logic [2:0] forward_terminal_sel_i,
    input wire logic [2:0] reverse_terminal_sel_i,
    input wire logic [2:0] enable_terminal_sel_i,
    // Configuration
    input wire logic [2:0] terminal_run_mode_sel_i,
    input wire logic stop_mode_sel_i,
    input wire logic [15:0] updown_step_size_i,
    input wire logic [15:0] updown_change_rate_i,
    input wire logic [15:0] decel_step_i,
    input wire logic direction_memory_en_i,
    input wire logic autostart_on_powerup_en_i,
    input wire logic [14:0] autostart_delay_i,
    input wire logic freq_memory_en_i,
    input wire logic [15:0] default_target_freq_i,
    // Retained state restored at power-up
    input wire logic [15:0] saved_freq_i,
    input wire logic [1:0] saved_cmd_i,
    input wire logic saved_dir_i,
    // Command from other sources when terminals are off
    input wire logic [1:0] other_source_cmd_i,
    // Status
    output logic [1:0] run_cmd_o,
    output logic output_en_o,
    output logic reverse_o,
    output logic autostart_wait_o,
    output logic [15:0] target_freq_o,
    output logic [15:0] out_freq_o,
    output logic remembered_dir_o
);
    localparam int unsigned TICK_CYC = `DRCL_TICK_CYC;

    drcl_state_t state;
    drcl_state_t next_state;
    logic [4:0] di_level;
    logic [4:0] di_rise;
    logic up_level;
    logic up_rise;
    logic down_level;
    logic down_rise;
    logic [21:0] tick_cnt;
    logic tick;
    logic [3:0] tenth_cnt;
    logic [14:0] delay_cnt;
    logic [14:0] delay_lim;
    logic powerup_pend;
    logic fwd_lvl;
    logic rev_lvl;
    logic en_lvl;
    logic fwd_pls;
    logic rev_pls;
    drcl_cmd_t cur_cmd;
    drcl_cmd_t next_cmd;
    drcl_cmd_t req_cmd;
    logic [15:0] target;
    logic [15:0] freq;
    logic load_freq;
    logic coast;
    logic ramping;
    logic running;

    function automatic logic drcl_pick(input logic [4:0] v,
                                       input logic [2:0] sel);
        return (sel <= 3'h4) ? v[sel] : 1'b0;
    endfunction : drcl_pick

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_di
            drcl_input_filter u_filt (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .pin_i(digital_input_i[gi]),
                .level_o(di_level[gi]),
                .rise_o(di_rise[gi])
            );
        end
    endgenerate

    drcl_input_filter u_up (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(up_key_i),
        .level_o(up_level),
        .rise_o(up_rise)
    );

    drcl_input_filter u_down (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(down_key_i),
        .level_o(down_level),
        .rise_o(down_rise)
    );

    // Role mapping of the three terminals onto the five inputs
    always_comb begin
        fwd_lvl = drcl_pick(di_level, forward_terminal_sel_i);
        rev_lvl = drcl_pick(di_level, reverse_terminal_sel_i);
        en_lvl = drcl_pick(di_level, enable_terminal_sel_i);
        fwd_pls = drcl_pick(di_rise, forward_terminal_sel_i);
        rev_pls = drcl_pick(di_rise, reverse_terminal_sel_i);
    end

    // 10 ms tick shared by rate stepping and delay counting
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_cnt <= 22'h00_0000;
            tick <= 1'b0;
        end else if (tick_cnt == 22'(TICK_CYC - 1)) begin
            tick_cnt <= 22'h00_0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 22'h00_0001;
            tick <= 1'b0;
        end
    end

    // Command decode per terminal mode
    always_comb begin
        req_cmd = cur_cmd;
        unique case (terminal_run_mode_sel_i)
            `DRCL_MODE_OFF: begin
                req_cmd = drcl_cmd_t'(other_source_cmd_i);
                if (req_cmd == 2'b11) begin
                    req_cmd = DRCL_CMD_STOP;
                end
            end
            `DRCL_MODE_TWO_A: begin
                unique case ({rev_lvl, fwd_lvl})
                    2'b01: req_cmd = DRCL_CMD_FWD;
                    2'b10: req_cmd = DRCL_CMD_REV;
                    default: req_cmd = DRCL_CMD_STOP;
                endcase
            end
            `DRCL_MODE_TWO_B: begin
                req_cmd = !fwd_lvl ? DRCL_CMD_STOP
                        : (rev_lvl ? DRCL_CMD_REV : DRCL_CMD_FWD);
            end
            `DRCL_MODE_THREE_A: begin
                if (!en_lvl) begin
                    req_cmd = DRCL_CMD_STOP;
                end else if (fwd_pls) begin
                    req_cmd = DRCL_CMD_FWD;
                end else if (rev_pls) begin
                    req_cmd = DRCL_CMD_REV;
                end
            end
            `DRCL_MODE_THREE_B: begin
                if (!en_lvl) begin
                    req_cmd = DRCL_CMD_STOP;
                end else if (fwd_pls || cur_cmd != DRCL_CMD_STOP) begin
                    req_cmd = rev_lvl ? DRCL_CMD_REV : DRCL_CMD_FWD;
                end
            end
            `DRCL_MODE_PULSE: begin
                if (fwd_pls) begin
                    req_cmd = (cur_cmd == DRCL_CMD_STOP) ? DRCL_CMD_FWD
                            : DRCL_CMD_STOP;
                end else if (rev_pls) begin
                    req_cmd = (cur_cmd == DRCL_CMD_STOP) ? DRCL_CMD_REV
                            : DRCL_CMD_STOP;
                end
            end
            default: req_cmd = DRCL_CMD_STOP;
        endcase
    end

    // Any nonzero terminal mode shuts out the other run sources
    assign next_cmd = req_cmd;

    // Auto-start delay limit in 0.1 s units, clamped to its range
    always_comb begin
        delay_lim = autostart_delay_i;
        if (delay_lim < `DRCL_DELAY_MIN) begin
            delay_lim = `DRCL_DELAY_MIN;
        end else if (delay_lim > `DRCL_DELAY_MAX) begin
            delay_lim = `DRCL_DELAY_MAX;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            DRCL_ST_IDLE: begin
                if (powerup_pend && autostart_on_powerup_en_i &&
                    saved_cmd_i != 2'b00) begin
                    next_state = DRCL_ST_WAIT;
                end else if (next_cmd != DRCL_CMD_STOP) begin
                    next_state = DRCL_ST_RUN;
                end
            end
            DRCL_ST_WAIT: begin
                if (delay_cnt >= delay_lim) begin
                    next_state = DRCL_ST_RUN;
                end
            end
            DRCL_ST_RUN: begin
                if (next_cmd == DRCL_CMD_STOP) begin
                    next_state = (stop_mode_sel_i == `DRCL_STOP_COAST)
                               ? DRCL_ST_IDLE : DRCL_ST_RAMP;
                end
            end
            DRCL_ST_RAMP: begin
                if (next_cmd != DRCL_CMD_STOP) begin
                    next_state = DRCL_ST_RUN;
                end else if (freq == 16'h0000) begin
                    next_state = DRCL_ST_IDLE;
                end
            end
            default: next_state = DRCL_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= DRCL_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Power-up is the first cycle out of reset; it is consumed once
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            powerup_pend <= 1'b1;
        end else if (state == DRCL_ST_IDLE) begin
            powerup_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || state != DRCL_ST_WAIT) begin
            tenth_cnt <= 4'h0;
            delay_cnt <= 15'h0000;
        end else if (tick) begin
            if (tenth_cnt == 4'(`DRCL_TICKS_PER_TENTH - 1)) begin
                tenth_cnt <= 4'h0;
                delay_cnt <= delay_cnt + 15'h0001;
            end else begin
                tenth_cnt <= tenth_cnt + 4'h1;
            end
        end
    end

    // Current direction command; auto-start restores the prior one
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cur_cmd <= DRCL_CMD_STOP;
        end else if (state == DRCL_ST_WAIT && next_state == DRCL_ST_RUN) begin
            cur_cmd <= (saved_cmd_i == 2'b10) ? DRCL_CMD_REV
                     : DRCL_CMD_FWD;
        end else if (state == DRCL_ST_WAIT) begin
            cur_cmd <= DRCL_CMD_STOP;
        end else begin
            cur_cmd <= next_cmd;
        end
    end

    // Direction memory, loaded from retained state after reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            remembered_dir_o <= 1'b0;
        end else if (powerup_pend) begin
            remembered_dir_o <= direction_memory_en_i & saved_dir_i;
        end else if (!direction_memory_en_i) begin
            remembered_dir_o <= 1'b0;
        end else if (cur_cmd == DRCL_CMD_FWD) begin
            remembered_dir_o <= 1'b0;
        end else if (cur_cmd == DRCL_CMD_REV) begin
            remembered_dir_o <= 1'b1;
        end
    end

    assign running = (state == DRCL_ST_RUN);
    assign ramping = (state == DRCL_ST_RAMP);
    assign coast = (state == DRCL_ST_RUN) && (next_state == DRCL_ST_IDLE);
    // Frequency memory picks the restored value, else the default
    assign load_freq = powerup_pend;

    drcl_freq_ramp u_ramp (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .step_size_i(updown_step_size_i),
        .change_rate_i(updown_change_rate_i),
        .decel_step_i(decel_step_i),
        .init_freq_i(freq_memory_en_i ? saved_freq_i
                                      : default_target_freq_i),
        .load_i(load_freq),
        .running_i(running),
        .up_press_i(up_rise),
        .down_press_i(down_rise),
        .up_hold_i(up_level),
        .down_hold_i(down_level),
        .ramp_down_i(ramping),
        .coast_i(coast),
        .target_o(target),
        .out_freq_o(freq)
    );

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_cmd_o <= 2'b00;
            output_en_o <= 1'b0;
            reverse_o <= 1'b0;
            autostart_wait_o <= 1'b0;
            target_freq_o <= 16'h0000;
            out_freq_o <= 16'h0000;
        end else begin
            run_cmd_o <= cur_cmd;
            output_en_o <= running || ramping;
            if (cur_cmd == DRCL_CMD_REV) begin
                reverse_o <= 1'b1;
            end else if (cur_cmd == DRCL_CMD_FWD) begin
                reverse_o <= 1'b0;
            end else if (terminal_run_mode_sel_i == `DRCL_MODE_THREE_A) begin
                reverse_o <= remembered_dir_o;
            end
            autostart_wait_o <= (state == DRCL_ST_WAIT);
            target_freq_o <= target;
            out_freq_o <= freq;
        end
    end
endmodule : drcl_run_ctrl
`default_nettype wire

// [logic/drcl_defines.svh]
// Constants for the drive run-command terminal logic
`ifndef DRCL_DEFINES_SVH
`define DRCL_DEFINES_SVH

// Clock rate
`define DRCL_CLK_HZ 250000000
// Terminal operation modes
`define DRCL_MODE_OFF 3'h0
`define DRCL_MODE_TWO_A 3'h1
`define DRCL_MODE_TWO_B 3'h2
`define DRCL_MODE_THREE_A 3'h3
`define DRCL_MODE_THREE_B 3'h4
`define DRCL_MODE_PULSE 3'h5
// Stop modes
`define DRCL_STOP_RAMP 1'b0
`define DRCL_STOP_COAST 1'b1
// Frequency in units of 0.01 Hz
`define DRCL_FREQ_W 16
`define DRCL_STANDBY_STEP 16'h0001
`define DRCL_STEP_MIN 16'h0001
`define DRCL_STEP_MAX 16'h00C8
`define DRCL_RATE_MAX 16'h2710
`define DRCL_RATE_RESET 16'h01F4
`define DRCL_FREQ_MAX 16'hFFFF
// Tick of 10 ms for rate stepping and delay counting
`define DRCL_TICK_MS 10
`define DRCL_TICK_CYC ((`DRCL_CLK_HZ / 1000) * `DRCL_TICK_MS)
// Auto-start delay in 0.1 s units, 0.1 s .. 3000.0 s
`define DRCL_DELAY_W 15
`define DRCL_DELAY_MIN 15'h0001
`define DRCL_DELAY_MAX 15'h7530
`define DRCL_DELAY_RESET 15'h0258
`define DRCL_TICKS_PER_TENTH 10
// Debounce hold in microseconds; bounce longer than this counts as a press
`define DRCL_DEB_US 4
`define DRCL_DEB_CYC ((`DRCL_CLK_HZ / 1000000) * `DRCL_DEB_US)

`endif

// [logic/drcl_pkg.sv]
// Types for the drive run-command terminal logic
package drcl_pkg;
    typedef enum logic [1:0] {
        DRCL_CMD_STOP = 2'b00,
        DRCL_CMD_FWD = 2'b01,
        DRCL_CMD_REV = 2'b10
    } drcl_cmd_t;

    typedef enum logic [3:0] {
        DRCL_ST_IDLE = 4'b0001,
        DRCL_ST_WAIT = 4'b0010,
        DRCL_ST_RUN = 4'b0100,
        DRCL_ST_RAMP = 4'b1000
    } drcl_state_t;
endpackage : drcl_pkg

// [logic/drcl_input_filter.sv]
// Three-stage synchroniser and debounce for one terminal input
`include "drcl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module drcl_input_filter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Raw pin and filtered level
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);
    localparam int unsigned DEB_CYC = `DRCL_DEB_CYC;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic [17:0] hold_cnt;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Level is taken only after stages two and three agree for a hold
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hold_cnt <= 18'h0_0000;
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (sync_b != sync_c || sync_c == level_o) begin
                hold_cnt <= 18'h0_0000;
            end else if (hold_cnt == 18'(DEB_CYC - 1)) begin
                hold_cnt <= 18'h0_0000;
                level_o <= sync_c;
                rise_o <= sync_c;
            end else begin
                hold_cnt <= hold_cnt + 18'h0_0001;
            end
        end
    end
endmodule : drcl_input_filter
`default_nettype wire

// [logic/drcl_freq_ramp.sv]
// Target frequency stepping and output frequency ramp
`include "drcl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module drcl_freq_ramp (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Timing
    input wire logic tick_i,
    // Settings
    input wire logic [15:0] step_size_i,
    input wire logic [15:0] change_rate_i,
    input wire logic [15:0] decel_step_i,
    input wire logic [15:0] init_freq_i,
    input wire logic load_i,
    // Operator controls
    input wire logic running_i,
    input wire logic up_press_i,
    input wire logic down_press_i,
    input wire logic up_hold_i,
    input wire logic down_hold_i,
    input wire logic ramp_down_i,
    input wire logic coast_i,
    // Results
    output logic [15:0] target_o,
    output logic [15:0] out_freq_o
);
    logic [15:0] step;
    logic [15:0] hold_step;
    logic [16:0] up_sum;

    function automatic logic [15:0] drcl_clamp_step(input logic [15:0] s);
        if (s < `DRCL_STEP_MIN) begin
            return `DRCL_STEP_MIN;
        end else if (s > `DRCL_STEP_MAX) begin
            return `DRCL_STEP_MAX;
        end
        return s;
    endfunction : drcl_clamp_step

    always_comb begin
        // Standby steps are fixed, running steps follow the setting
        step = running_i ? drcl_clamp_step(step_size_i)
                         : `DRCL_STANDBY_STEP;
        // Rate is in 0.01 Hz/s; per 10 ms tick that is rate/100
        hold_step = (change_rate_i > `DRCL_RATE_MAX) ? 16'(`DRCL_RATE_MAX / 100)
                  : 16'(change_rate_i / 16'h0064);
        if (hold_step == 16'h0000) begin
            hold_step = 16'h0001;
        end
        up_sum = {1'b0, target_o} + {1'b0, step};
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            target_o <= 16'h0000;
        end else if (load_i) begin
            target_o <= init_freq_i;
        end else if (up_press_i) begin
            target_o <= up_sum[16] ? `DRCL_FREQ_MAX : up_sum[15:0];
        end else if (down_press_i) begin
            target_o <= (target_o > step) ? target_o - step : 16'h0000;
        end else if (tick_i && up_hold_i) begin
            target_o <= (`DRCL_FREQ_MAX - target_o > hold_step)
                      ? target_o + hold_step : `DRCL_FREQ_MAX;
        end else if (tick_i && down_hold_i) begin
            target_o <= (target_o > hold_step)
                      ? target_o - hold_step : 16'h0000;
        end
    end

    // Output frequency follows target while running, decays on a ramp stop, drops to zero on a coast stop
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_freq_o <= 16'h0000;
        end else if (coast_i) begin
            out_freq_o <= 16'h0000;
        end else if (tick_i && ramp_down_i) begin
            out_freq_o <= (out_freq_o > decel_step_i)
                        ? out_freq_o - decel_step_i : 16'h0000;
        end else if (running_i && !ramp_down_i) begin
            out_freq_o <= target_o;
        end
    end
endmodule : drcl_freq_ramp
`default_nettype wire

// [tb/drcl_run_chk.sv]
// Concurrent checks on the run-command block ports
`timescale 1ns/1ns
`default_nettype none
module drcl_run_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Settings
    input wire logic [2:0] terminal_run_mode_sel_i,
    input wire logic stop_mode_sel_i,
    input wire logic autostart_on_powerup_en_i,
    input wire logic [1:0] saved_cmd_i,
    input wire logic [1:0] other_source_cmd_i,
    // Status
    input wire logic [1:0] run_cmd_o,
    input wire logic output_en_o,
    input wire logic autostart_wait_o,
    input wire logic [15:0] target_freq_o,
    input wire logic [15:0] out_freq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [2:0] age;
    // Target steps are judged only once the power-up load has settled
    always_ff @(posedge clk_i) begin
        if (srst_i) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    AST_BAD_MODE: assert property ((terminal_run_mode_sel_i > 3'h5)[*3]
        |-> run_cmd_o == 2'h0) else $error("unused mode ran");
    AST_SRC: assert property (((terminal_run_mode_sel_i == 3'h0)
        && $stable(other_source_cmd_i) && !autostart_wait_o)[*3]
        |-> run_cmd_o == ((other_source_cmd_i == 2'h3) ? 2'h0
        : other_source_cmd_i)) else $error("other source not followed");
    AST_RUN_EN: assert property ((run_cmd_o != 2'h0)[*2]
        |-> output_en_o) else $error("run without output");
    AST_COAST: assert property ((stop_mode_sel_i && run_cmd_o == 2'h0)[*3]
        |-> !output_en_o) else $error("coast stop kept output");
    AST_RAMP: assert property (!stop_mode_sel_i && $past(output_en_o)
        && out_freq_o != 16'h0000 |-> output_en_o)
        else $error("ramp stop cut output early");
    AST_WAIT: assert property (autostart_wait_o
        |-> run_cmd_o == 2'h0 && !output_en_o) else $error("ran in delay");
    AST_AUTO: assert property ($fell(srst_i) && autostart_on_powerup_en_i
        && saved_cmd_i != 2'h0 |-> ##[1:3] autostart_wait_o)
        else $error("no auto-start delay");
    AST_NO_AUTO: assert property ($fell(srst_i)
        && !autostart_on_powerup_en_i |-> !autostart_wait_o[*8])
        else $error("auto-start while disabled");
    AST_STBY_STEP: assert property (age == 3'h7 && !output_en_o
        && !$past(output_en_o) && $changed(target_freq_o)
        |-> 16'(target_freq_o - $past(target_freq_o)) inside
        {16'h0001, 16'hffff}) else $error("standby step not one");
    AST_RUN_STEP: assert property (age == 3'h7 && output_en_o
        && $past(output_en_o) && $changed(target_freq_o)
        |-> 16'(target_freq_o - $past(target_freq_o)) <= 16'h00c8
        || 16'($past(target_freq_o) - target_freq_o) <= 16'h00c8)
        else $error("running step too large");
    cover property (terminal_run_mode_sel_i == 3'h5 && run_cmd_o == 2'h2);
    cover property (stop_mode_sel_i && $fell(output_en_o));
    cover property (autostart_wait_o);
endmodule : drcl_run_chk
bind drcl_run_ctrl drcl_run_chk u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .terminal_run_mode_sel_i(terminal_run_mode_sel_i),
    .stop_mode_sel_i(stop_mode_sel_i),
    .autostart_on_powerup_en_i(autostart_on_powerup_en_i),
    .saved_cmd_i(saved_cmd_i), .other_source_cmd_i(other_source_cmd_i),
    .run_cmd_o(run_cmd_o), .output_en_o(output_en_o),
    .autostart_wait_o(autostart_wait_o), .target_freq_o(target_freq_o),
    .out_freq_o(out_freq_o));
`default_nettype wire

// [tb/drcl_panel.sv]
// Operator switches and push buttons wired to the terminals
`timescale 1ns/1ns
`default_nettype none
module drcl_panel #(
    parameter int HOLD = 1000
) (
    // Clock
    input wire logic clk_i,
    // Switch levels and one-cycle press requests
    input wire logic [6:0] lvl_i,
    input wire logic [6:0] press_i,
    // Contact state, high when closed
    output logic [6:0] pins_o
);
    logic [6:0] held = 7'h00;
    int cnt = 0;
    // A press stays closed past the debounce, else it is never seen
    always_ff @(posedge clk_i) begin
        if (press_i != 7'h00) begin
            held <= press_i;
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            held <= 7'h00;
        end
    end
    assign pins_o = lvl_i | held;
endmodule : drcl_panel
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the run-command block
`include "drcl_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int WAIT = `DRCL_DEB_CYC + 40;
    typedef struct {
        logic [2:0] mode;
        logic [6:0] lvl;
        logic [1:0] other;
        logic [1:0] cmd;
    } drcl_row_t;
    // Terminal roles: forward bit 3, reverse bit 0, enable bit 4
    drcl_row_t rows [10] = '{'{3'h1, 7'h00, 2'h0, 2'h0},
        '{3'h1, 7'h08, 2'h0, 2'h1}, '{3'h1, 7'h01, 2'h0, 2'h2},
        '{3'h1, 7'h09, 2'h0, 2'h0}, '{3'h2, 7'h09, 2'h0, 2'h2},
        '{3'h2, 7'h08, 2'h0, 2'h1}, '{3'h2, 7'h01, 2'h0, 2'h0},
        '{3'h6, 7'h08, 2'h0, 2'h0}, '{3'h0, 7'h00, 2'h2, 2'h2},
        '{3'h1, 7'h00, 2'h2, 2'h0}};
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [6:0] lvl = 7'h00;
    logic [6:0] press = 7'h00;
    logic [6:0] pins;
    logic [2:0] mode = 3'h0;
    logic stop_mode = 1'b0;
    logic dmem = 1'b0;
    logic auto_en = 1'b0;
    logic [1:0] scmd = 2'h0;
    logic [1:0] other = 2'h0;
    logic [2:0] fsel = 3'h3, rsel = 3'h0, esel = 3'h4;
    logic fmem = 1'b0, sdir = 1'b0;
    logic [15:0] dstep = 16'h0001;
    logic [1:0] run_cmd;
    logic en, reverse_terminal, awt, rdir;
    logic [15:0] tgt, ofq;
    int num_errors = 0;
    int tests_run = 0;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    drcl_panel #(.HOLD(`DRCL_DEB_CYC + 20)) u_panel (.clk_i(clk_i),
        .lvl_i(lvl), .press_i(press), .pins_o(pins));

    drcl_run_ctrl dut (.clk_i(clk_i), .srst_i(srst_i),
        .digital_input_i(pins[4:0]), .up_key_i(pins[5]),
        .down_key_i(pins[6]), .forward_terminal_sel_i(fsel),
        .reverse_terminal_sel_i(rsel), .enable_terminal_sel_i(esel),
        .terminal_run_mode_sel_i(mode), .stop_mode_sel_i(stop_mode),
        .updown_step_size_i(16'h0032), .updown_change_rate_i(16'h01f4),
        .decel_step_i(dstep), .direction_memory_en_i(dmem),
        .autostart_on_powerup_en_i(auto_en), .autostart_delay_i(15'h0001),
        .freq_memory_en_i(fmem), .default_target_freq_i(16'h03e8),
        .saved_freq_i(16'h07d0), .saved_cmd_i(scmd), .saved_dir_i(sdir),
        .other_source_cmd_i(other), .run_cmd_o(run_cmd),
        .output_en_o(en), .reverse_o(reverse_terminal), .autostart_wait_o(awt),
        .target_freq_o(tgt), .out_freq_o(ofq), .remembered_dir_o(rdir));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task press_key(input int idx);
        @(posedge clk_i);
        press <= 7'h01 << idx;
        @(posedge clk_i);
        press <= 7'h00;
        cyc(2 * WAIT);
    endtask : press_key

    task set_lvl(input logic [6:0] v);
        @(posedge clk_i);
        lvl <= v;
        cyc(WAIT);
    endtask : set_lvl

    task test_done;
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    // Some thirty debounced changes of about a thousand cycles each
    initial begin
        cyc(50000);
        num_errors++;
        test_done();
    end

    initial begin
        cyc(3);
        check(16'({run_cmd, en, reverse_terminal, awt}), 16'h0000);
        check(ofq, 16'h0000);
        cyc(2);
        srst_i <= 1'b0;
        cyc(20);
        check(16'({run_cmd, en, awt}), 16'h0000);
        check(tgt, 16'h03e8);
        // Key steps come first, before the first slow rate tick
        press_key(5);
        check(tgt, 16'h03e9);
        other <= 2'h1;
        cyc(8);
        check(16'(run_cmd), 16'h0001);
        press_key(5);
        check(tgt, 16'h041b);
        check(ofq, 16'h041b);
        stop_mode <= 1'b1;
        other <= 2'h0;
        cyc(4);
        check(16'(en), 16'h0000);
        check(ofq, 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk_i);
            mode <= rows[i].mode;
            other <= rows[i].other;
            lvl <= rows[i].lvl;
            cyc((rows[i].lvl != lvl) ? WAIT : 8);
            check(16'(run_cmd), 16'(rows[i].cmd));
        end
        fsel <= 3'h2;
        set_lvl(7'h04);
        check(16'(run_cmd), 16'h0001);
        fsel <= 3'h3;
        @(posedge clk_i);
        mode <= 3'h5;
        press_key(3);
        check(16'(run_cmd), 16'h0001);
        press_key(0);
        check(16'(run_cmd), 16'h0000);
        press_key(0);
        check(16'(run_cmd), 16'h0002);
        press_key(0);
        check(16'(run_cmd), 16'h0000);
        @(posedge clk_i);
        mode <= 3'h3;
        dmem <= 1'b1;
        set_lvl(7'h10);
        check(16'(run_cmd), 16'h0000);
        press_key(0);
        check(16'(run_cmd), 16'h0002);
        check(16'(rdir), 16'h0001);
        set_lvl(7'h00);
        check(16'(run_cmd), 16'h0000);
        press_key(3);
        check(16'(run_cmd), 16'h0000);
        @(posedge clk_i);
        mode <= 3'h4;
        set_lvl(7'h10);
        press_key(3);
        check(16'(run_cmd), 16'h0001);
        set_lvl(7'h11);
        check(16'(run_cmd), 16'h0002);
        check(16'(reverse_terminal), 16'h0001);
        set_lvl(7'h00);
        check(16'(run_cmd), 16'h0000);
        @(posedge clk_i);
        auto_en <= 1'b1;
        scmd <= 2'h1;
        fmem <= 1'b1;
        sdir <= 1'b1;
        srst_i <= 1'b1;
        cyc(5);
        srst_i <= 1'b0;
        cyc(6);
        check(16'(awt), 16'h0001);
        check(16'(run_cmd), 16'h0000);
        check(tgt, 16'h07d0);
        check(16'(rdir), 16'h0001);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
